/* charger_cfg_pkg.sv */
// package for the charging-box configuration and watchdog register bank
// assumes a 32-bit AXI4-Lite slave with one 16-bit register per word
package charger_cfg_pkg;

  // ----------------------------------------------------------------------
  // register map (register index, byte address is index times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h03;
  localparam logic [7:0] IDX_CFG_ONE = 8'h04;
  localparam logic [7:0] IDX_CFG_TWO = 8'h05;
  localparam logic [7:0] IDX_CFG_THREE = 8'h06;
  localparam logic [7:0] IDX_WATCHDOG = 8'h0b;
  localparam logic [7:0] IDX_WDG_STATUS = 8'h0c;

  // ----------------------------------------------------------------------
  // writable bits and reset words
  // ----------------------------------------------------------------------
  localparam logic [15:0] CFG_ONE_MASK = 16'h003f;
  localparam logic [15:0] CFG_TWO_MASK = 16'h1fff;
  localparam logic [15:0] CFG_THREE_MASK = 16'h007f;
  localparam logic [15:0] WATCHDOG_ENABLE_MASK = 16'h0001;
  localparam logic [15:0] WDG_PRESET_MASK = 16'h03fe;
  localparam logic [15:0] CFG_ONE_RST = 16'h002a;
  localparam logic [15:0] CFG_TWO_RST = 16'h1151;
  localparam logic [15:0] CFG_THREE_RST = 16'h0022;
  localparam logic [15:0] WDG_RST = 16'h03fe;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int LED_LSB = 4;
  localparam int BOOST_LSB = 2;
  localparam int OFFSET_LSB = 0;
  localparam int RAIL_LSB = 10;
  localparam int INLIM_LSB = 8;
  localparam int PCH_I_LSB = 6;
  localparam int PCH_V_LSB = 4;
  localparam int CC_I_LSB = 2;
  localparam int RCH_LSB = 0;
  localparam int EAR_LIM_LSB = 5;
  localparam int CC_V_LSB = 2;
  localparam int TERM_LSB = 0;
  localparam int WATCHDOG_ENABLE_BIT = 0;
  localparam int WDG_PRESET_LSB = 1;
  localparam int WDG_SERVICE_BIT = 13;
  localparam int WSTAT_FLAG_BIT = 0;

  // ----------------------------------------------------------------------
  // encodings and bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] PCH_150_CODE = 2'b10;
  localparam logic [2:0] CC_V_MAX_CODE = 3'b100;
  localparam logic [2:0] CC_V_DEFAULT = 3'b000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 40;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_RUN = 2'b01,
    WD_EXPIRED = 2'b11
  } wd_state_t;

  typedef struct packed {
    logic [1:0] led_current_select;
    logic [1:0] boost_peak_limit_select;
    logic [1:0] light_load_offset;
    logic [2:0] system_rail_select;
    logic [1:0] input_limit_trim;
    logic [1:0] precharge_current_scale;
    logic [1:0] precharge_end_voltage;
    logic [1:0] cc_charge_scale;
    logic [1:0] recharge_threshold;
    logic [1:0] earbud_output_limit;
    logic [2:0] cc_end_voltage;
    logic [1:0] termination_current_trim;
  } charger_cfg_t;

endpackage

/* charger_box_user_config_watchdog_regs.sv */
// configuration register bank and watchdog of a charging-box power manager
// assumes an AXI4-Lite master on aclk; fields drive analog trims outside
//
// Overview of operation
// - boost peak limit code, bits 3:2, reset 10
// - light-load offset code, bits 1:0, reset 10
// - system rail code, bits 12:10, reset 100
// - input limit trim, bits 9:8, reset 01
// - precharge scale, codes 10 and 11 both 150%
// - precharge end voltage, bits 5:4, reset 01
// - cc charge scale, bits 3:2, reset 00
// - recharge threshold, bits 1:0, reset 01
// - earbud output limit, bits 6:5, reset 01
// - cc end voltage, unused codes mean 4.2V
// - termination trim, bits 1:0, reset 10
// - watchdog preset 9:1 and enable; preset locked while enabled
// - reserved bits read zero, written zero
// - service bit restarts watchdog and self-clears
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module charger_box_user_config_watchdog_regs
  import charger_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS
) (
  input wire logic aclk, // 25 MHz clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output charger_cfg_t cfg, // decoded trim and select fields
  output logic watchdog_timeout // high while watchdog expired
);

  // ----------------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [15:0] cfg_one_q, cfg_two_q, cfg_three_q, wdg_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire, wr_hit;
  logic [15:0] wr_mask;
  logic service_pulse, flag_clear;
  wd_state_t wd_state_q;
  logic [8:0] wd_count_q;
  logic [PRE_W-1:0] pre_q;
  logic tick;
  logic flag_q;
  logic [15:0] rd_word;
  logic rd_hit;

  // ----------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // hold each half until the pair is complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // unmapped writes still answer, with an error
  always_comb begin
    if (aw_addr_q == byte_addr(IDX_CONTROL)) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == byte_addr(IDX_CFG_ONE)) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == byte_addr(IDX_CFG_TWO)) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == byte_addr(IDX_CFG_THREE)) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == byte_addr(IDX_WATCHDOG)) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == byte_addr(IDX_WDG_STATUS)) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // response one cycle after the pair completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // reserved bits never store, so they read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_one_q <= CFG_ONE_RST;
      cfg_two_q <= CFG_TWO_RST;
      cfg_three_q <= CFG_THREE_RST;
    end else if (wr_fire) begin
      if (aw_addr_q == byte_addr(IDX_CFG_ONE)) begin
        cfg_one_q <= (cfg_one_q & ~wr_mask)
          | (w_data_q[15:0] & wr_mask & CFG_ONE_MASK);
      end else if (aw_addr_q == byte_addr(IDX_CFG_TWO)) begin
        cfg_two_q <= (cfg_two_q & ~wr_mask)
          | (w_data_q[15:0] & wr_mask & CFG_TWO_MASK);
      end else if (aw_addr_q == byte_addr(IDX_CFG_THREE)) begin
        cfg_three_q <= (cfg_three_q & ~wr_mask)
          | (w_data_q[15:0] & wr_mask & CFG_THREE_MASK);
      end
    end
  end

  // watchdog word: preset bits only move while the watchdog is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdg_q <= WDG_RST;
    end else if (wr_fire && aw_addr_q == byte_addr(IDX_WATCHDOG)) begin
      if (wdg_q[WATCHDOG_ENABLE_BIT]) begin
        wdg_q <= (wdg_q & ~(wr_mask & WATCHDOG_ENABLE_MASK))
          | (w_data_q[15:0] & wr_mask & WATCHDOG_ENABLE_MASK);
      end else begin
        wdg_q <= (wdg_q & ~wr_mask) | (w_data_q[15:0] & wr_mask
          & (WATCHDOG_ENABLE_MASK | WDG_PRESET_MASK));
      end
    end
  end

  // ----------------------------------------------------------------------
  // field outputs, with the two documented code aliases folded
  // ----------------------------------------------------------------------
  always_comb begin
    cfg.led_current_select = cfg_one_q[LED_LSB +: 2];
    cfg.boost_peak_limit_select = cfg_one_q[BOOST_LSB +: 2];
    cfg.light_load_offset = cfg_one_q[OFFSET_LSB +: 2];
    cfg.system_rail_select = cfg_two_q[RAIL_LSB +: 3];
    cfg.input_limit_trim = cfg_two_q[INLIM_LSB +: 2];
    cfg.precharge_current_scale = cfg_two_q[PCH_I_LSB +: 2];
    if (cfg_two_q[PCH_I_LSB + 1]) begin
      cfg.precharge_current_scale = PCH_150_CODE;
    end
    cfg.precharge_end_voltage = cfg_two_q[PCH_V_LSB +: 2];
    cfg.cc_charge_scale = cfg_two_q[CC_I_LSB +: 2];
    cfg.recharge_threshold = cfg_two_q[RCH_LSB +: 2];
    cfg.earbud_output_limit = cfg_three_q[EAR_LIM_LSB +: 2];
    cfg.cc_end_voltage = cfg_three_q[CC_V_LSB +: 3];
    if (cfg_three_q[CC_V_LSB +: 3] > CC_V_MAX_CODE) begin
      cfg.cc_end_voltage = CC_V_DEFAULT;
    end
    cfg.termination_current_trim = cfg_three_q[TERM_LSB +: 2];
  end

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  // service bit is never stored, so it reads back as zero
  assign service_pulse = wr_fire && aw_addr_q == byte_addr(IDX_CONTROL)
    && w_strb_q[1] && w_data_q[WDG_SERVICE_BIT];
  assign flag_clear = wr_fire && aw_addr_q == byte_addr(IDX_WDG_STATUS)
    && w_strb_q[0] && w_data_q[WSTAT_FLAG_BIT];
  assign tick = pre_q == TICK_LAST;
  assign watchdog_timeout = wd_state_q == WD_EXPIRED;

  // prescaler restarts with each reload so a service gives a full period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else if (wd_state_q != WD_RUN || service_pulse || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_state_q <= WD_OFF;
      wd_count_q <= WDG_RST[WDG_PRESET_LSB +: 9];
    end else if (!wdg_q[WATCHDOG_ENABLE_BIT]) begin
      wd_state_q <= WD_OFF;
      wd_count_q <= wdg_q[WDG_PRESET_LSB +: 9];
    end else begin
      case (wd_state_q)
        WD_OFF: begin
          wd_state_q <= WD_RUN;
          wd_count_q <= wdg_q[WDG_PRESET_LSB +: 9];
        end
        WD_RUN: begin
          if (service_pulse) begin
            wd_count_q <= wdg_q[WDG_PRESET_LSB +: 9];
          end else if (tick && wd_count_q == '0) begin
            wd_state_q <= WD_EXPIRED;
          end else if (tick) begin
            wd_count_q <= wd_count_q - 1'b1;
          end
        end
        WD_EXPIRED: begin
          if (service_pulse) begin
            wd_state_q <= WD_RUN;
            wd_count_q <= wdg_q[WDG_PRESET_LSB +: 9];
          end
        end
        default: begin
          wd_state_q <= WD_OFF;
        end
      endcase
    end
  end

  // sticky expiry flag; a new expiry beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (wd_state_q == WD_RUN && tick && wd_count_q == '0
                 && !service_pulse && wdg_q[WATCHDOG_ENABLE_BIT]) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == byte_addr(IDX_CONTROL)) begin
      rd_word = 16'h0000;
    end else if (s_axi_araddr == byte_addr(IDX_CFG_ONE)) begin
      rd_word = cfg_one_q;
    end else if (s_axi_araddr == byte_addr(IDX_CFG_TWO)) begin
      rd_word = cfg_two_q;
    end else if (s_axi_araddr == byte_addr(IDX_CFG_THREE)) begin
      rd_word = cfg_three_q;
    end else if (s_axi_araddr == byte_addr(IDX_WATCHDOG)) begin
      rd_word = wdg_q;
    end else if (s_axi_araddr == byte_addr(IDX_WDG_STATUS)) begin
      rd_word = {6'h00, wd_count_q, flag_q};
    end else begin
      rd_word = 16'h0000;
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // data answered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cfg_one_write: assert property (
    wr_fire && aw_addr_q == byte_addr(IDX_CFG_ONE) && w_strb_q[0]
    |=> cfg.boost_peak_limit_select == $past(w_data_q[3:2])
        && cfg.led_current_select == $past(w_data_q[5:4]))
    else $error("first config write not applied");

  a_reset_words: assert property (
    $rose(aresetn) |-> cfg_one_q == CFG_ONE_RST
      && cfg_two_q == CFG_TWO_RST && cfg_three_q == CFG_THREE_RST
      && wdg_q == WDG_RST)
    else $error("config reset words wrong");

  a_rail_write: assert property (
    wr_fire && aw_addr_q == byte_addr(IDX_CFG_TWO) && w_strb_q[1]
    |=> cfg.system_rail_select == $past(w_data_q[12:10]))
    else $error("rail select not applied");

  a_precharge_alias: assert property (
    cfg_two_q[7:6] == 2'b11 |-> cfg.precharge_current_scale == 2'b10)
    else $error("precharge code 11 not folded");

  a_cc_end_fold: assert property (
    cfg_three_q[4:2] > 3'b100 |-> cfg.cc_end_voltage == 3'b000)
    else $error("unused cc end code not folded");

  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
      && cfg_one_q[15:6] == '0 && cfg_three_q[15:7] == '0)
    else $error("reserved bits not zero");

  a_preset_locked: assert property (
    wr_fire && wdg_q[0] |=> wdg_q[9:1] == $past(wdg_q[9:1]))
    else $error("preset changed while enabled");

  a_map_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == byte_addr(IDX_WATCHDOG)
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
        && s_axi_rdata[15:0] == $past(wdg_q))
    else $error("watchdog register read wrong");

  a_service_reload: assert property (
    service_pulse && wdg_q[0] && wd_state_q != WD_OFF
    |=> wd_state_q == WD_RUN && wd_count_q == $past(wdg_q[9:1]))
    else $error("service did not reload watchdog");

  a_expire_step: assert property (
    wd_state_q == WD_RUN && tick && wd_count_q == '0 && wdg_q[0]
      && !service_pulse
    |=> watchdog_timeout && flag_q)
    else $error("watchdog expiry missed");

  c_write_cfg: cover property (wr_fire && s_axi_bresp == RESP_OKAY);
  c_expire: cover property (wd_state_q == WD_RUN ##1 watchdog_timeout);
  c_service_rescue: cover property (watchdog_timeout ##1 service_pulse);
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

/* host_bus_model.sv */
// axi4-lite host model: the microcontroller side of the register bank
// assumes one aclk domain; the bench calls wr and rd hierarchically
`timescale 1ns/1ns
module host_bus_model (
  input wire logic aclk, // bus clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready, // read data ready
  output logic bus_hang // goes high and stays high when a wait runs out
);
  // --------------------------------------------------------------------
  // idle levels from time zero
  // --------------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, bus_hang} = 3'b000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
  end

  // --------------------------------------------------------------------
  // write: handshakes judged on values settled before each edge
  // --------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d; // callers keep reserved bits zero except on purpose
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    resp = 2'bxx;
    for (int n = 0; n < 200; n++) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        resp = r;
        return;
      end
    end
    bus_hang <= 1'b1;
  endtask

  // --------------------------------------------------------------------
  // read: address held until taken, rready until rvalid
  // --------------------------------------------------------------------
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    d = 32'hx;
    resp = 2'bxx;
    for (int n = 0; n < 200; n++) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    bus_hang <= 1'b1;
  endtask
endmodule

/* charger_box_user_config_watchdog_regs_tb.sv */
// self-checking bench for the configuration and watchdog register bank
// assumes host_bus_model as bus master; watchdog tick shortened to 4
`timescale 1ns/1ns
module charger_box_user_config_watchdog_regs_tb;
  import charger_cfg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire logic [7:0] awaddr, araddr;
  wire logic awvalid, awready, wvalid, wready, bvalid, bready;
  wire logic arvalid, arready, rvalid, rready, bus_hang;
  wire logic [31:0] wdata, rdata;
  wire logic [3:0] wstrb;
  wire logic [1:0] bresp, rresp;
  charger_cfg_t cfg;
  logic watchdog_timeout;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic [1:0] rs;

  // --------------------------------------------------------------------
  // clock, design and host
  // --------------------------------------------------------------------
  always #20 aclk = ~aclk;

  charger_box_user_config_watchdog_regs #(.TICK_CYCLES(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cfg(cfg), .watchdog_timeout(watchdog_timeout));

  host_bus_model i_host_bus_model (
    .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_hang(bus_hang));

  // --------------------------------------------------------------------
  // comparison and closing
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a stuck handshake ends the run with a mismatch
  always @(posedge bus_hang) begin
    fail_count++;
    wrap_up();
  end

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    i_host_bus_model.rd(a, d, rs);
    check(what, d, exp);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("cfg_one rst", 8'h10, 32'h002a);
    rd_chk("cfg_two rst", 8'h14, 32'h1151);
    rd_chk("cfg_three rst", 8'h18, 32'h0022);
    rd_chk("wdg rst", 8'h2c, 32'h03fe);
    check("cfg rst", {3'b0, cfg}, {3'b0, 2'b10, 2'b10, 2'b10, 3'b100,
      2'b01, 2'b01, 2'b01, 2'b00, 2'b01, 2'b01, 3'b000, 2'b10});
    check("timeout rst", {31'b0, watchdog_timeout}, 32'h0);
    $display("test reset values done");
  endtask

  // reserved bits set on purpose to prove they read back zero
  task automatic t_fields();
    i_host_bus_model.wr(8'h10, 32'h0000ffc6, rs);
    rd_chk("cfg_one", 8'h10, 32'h0006);
    i_host_bus_model.wr(8'h14, 32'h0000e9e6, rs);
    rd_chk("cfg_two", 8'h14, 32'h09e6);
    i_host_bus_model.wr(8'h18, 32'h0000ff95, rs);
    rd_chk("cfg_three", 8'h18, 32'h0015);
    check("cfg fields", {3'b0, cfg}, {3'b0, 2'b00, 2'b01, 2'b10, 3'b010,
      2'b01, 2'b10, 2'b10, 2'b01, 2'b10, 2'b00, 3'b000, 2'b01});
    // every cc end voltage code; codes above four fall back to 000
    for (int v = 0; v < 8; v++) begin
      i_host_bus_model.wr(8'h18, 32'(v) << 2, rs);
      check("cc_end_voltage", {29'b0, cfg.cc_end_voltage},
            (v > 4) ? 32'h0 : 32'(v));
    end
    $display("test field decode done");
  endtask

  task automatic t_unmapped();
    i_host_bus_model.wr(8'h3c, 32'h0000ffff, rs);
    check("bresp unmapped", {30'b0, rs}, 32'h2);
    i_host_bus_model.rd(8'h3c, d, rs);
    check("rdata unmapped", d, 32'h0);
    check("rresp unmapped", {30'b0, rs}, 32'h2);
    $display("test unmapped access done");
  endtask

  task automatic t_watchdog();
    int n;
    i_host_bus_model.wr(8'h2c, 32'h00000004, rs); // preset while disabled
    i_host_bus_model.wr(8'h2c, 32'h00000005, rs);
    i_host_bus_model.wr(8'h2c, 32'h00000011, rs);
    rd_chk("preset locked", 8'h2c, 32'h0005);
    n = 0;
    while (watchdog_timeout !== 1'b1 && n < 300) begin
      @(posedge aclk);
      #1;
      n++;
    end
    check("timeout raised", {31'b0, watchdog_timeout}, 32'h1);
    i_host_bus_model.wr(8'h0c, 32'h00002000, rs);
    #1;
    check("timeout serviced", {31'b0, watchdog_timeout}, 32'h0);
    rd_chk("service clears", 8'h0c, 32'h0);
    i_host_bus_model.wr(8'h2c, 32'h00000004, rs);
    #1;
    check("timeout off", {31'b0, watchdog_timeout}, 32'h0);
    i_host_bus_model.rd(8'h30, d, rs);
    check("count reload", d & 32'h3fe, 32'h4);
    check("sticky flag", d & 32'h1, 32'h1);
    $display("test watchdog done");
  endtask

  // --------------------------------------------------------------------
  // main sequence: reset held for 16 edges, released on an edge
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_unmapped();
    t_watchdog();
    wrap_up();
  end
endmodule
